// ==== logic/scsirs_pkg.sv ====
`default_nettype none

package scsirs_pkg;

	typedef logic [7:0] scsirs_byte_t;

	typedef enum logic {
		SCSIRS_DIR_RECV = 1'b0,
		SCSIRS_DIR_SEND = 1'b1
	} scsirs_dir_e;

endpackage

`default_nettype wire

// ==== logic/scsirs_regs.svh ====
`ifndef SCSIRS_REGS_SVH
`define SCSIRS_REGS_SVH

// ****************************************
// Read locations
// ****************************************
`define SCSIRS_LOC_DATA      3'h0
`define SCSIRS_LOC_ICR       3'h1
`define SCSIRS_LOC_MODE      3'h2
`define SCSIRS_LOC_TCR       3'h3
`define SCSIRS_LOC_CTRL      3'h4
`define SCSIRS_LOC_STATUS    3'h5
`define SCSIRS_LOC_HOLD      3'h6
`define SCSIRS_LOC_CLEAR     3'h7

// ****************************************
// Operating mode bit positions
// ****************************************
`define SCSIRS_MODE_DMA      1
`define SCSIRS_MODE_MONBSY   2
`define SCSIRS_MODE_EODMA_IE 3
`define SCSIRS_MODE_PAR_IE   4
`define SCSIRS_MODE_PAR_EN   5
`define SCSIRS_MODE_TARGET   6

// ****************************************
// Initiator command fields
// ****************************************
`define SCSIRS_ICR_ARB_BUSY  6
`define SCSIRS_ICR_ARB_LOST  5

// ****************************************
// Timing
// ****************************************
`define SCSIRS_CLK_NS        10
`define SCSIRS_SETTLE_NS     400
`define SCSIRS_EOP_MIN_NS    20
`define SCSIRS_SETTLE_CYC    ((`SCSIRS_SETTLE_NS + `SCSIRS_CLK_NS - 1) / `SCSIRS_CLK_NS)
`define SCSIRS_EOP_CYC       ((`SCSIRS_EOP_MIN_NS + `SCSIRS_CLK_NS - 1) / `SCSIRS_CLK_NS)

// ****************************************
// Receive buffer
// ****************************************
`define SCSIRS_FIFO_WIDTH    8
`define SCSIRS_FIFO_DEPTH    8

`endif

// ==== logic/scsirs_top.sv ====
// Function
// RULE1: Location 4 read shows control pins inverted, not stored.
// RULE2: Status bit 7 set by end, acknowledge and a strobe held minimum time.
// RULE3: End-of-transfer flag clears when software clears the transfer mode bit.
// RULE4: Loss of busy clears transfer mode bit, which clears end-of-transfer flag.
// RULE5: Software should read status before dropping its busy command bit.
// RULE6: Status bit 6 shows request; acknowledge plus write/read strobe drops it.
// RULE7: Clearing transfer mode bit drops request and its status bit.
// RULE8: With parity check enabled, bad odd parity sets status bit 5.
// RULE9: Status bit 4 shows the interrupt request latch.
// RULE10: Status bit 3 is live phase line compare; mismatch inhibits transfer.
// RULE11: With busy monitoring, busy false 400 ns sets status bit 2.
// RULE12: Busy error disables bus drivers, clears transfer mode and command bits 5-0.
// RULE13: Status bits 1 and 0 show attention and acknowledge pins inverted, live.
// RULE14: In transfer mode, data captured on request (initiator) or acknowledge (target).
// RULE15: Holding register read by acknowledge plus read strobe, or location 6.
// RULE16: Host never asserts acknowledge and chip select together.
// RULE17: Parity optionally checked on each byte entering the holding register.
// RULE18: Reading location 7 clears interrupt latch, parity and busy error flags.
// RULE19: Interrupt output follows latch except in test float mode, then floats.
// RULE20: Six interrupt causes, mostly maskable, all set one latch.
// RULE21: Bus reset becoming active raises an unmaskable interrupt.
// RULE22: Software treats an interrupt with no other cause visible as bus reset.
`timescale 1ns/10ps
`default_nettype none
`include "scsirs_regs.svh"

// ****************************************
// Receive buffer
// ****************************************
module scsirs_fifo #(
	parameter int WIDTH = `SCSIRS_FIFO_WIDTH,
	parameter int DEPTH = `SCSIRS_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_q;
	logic [AW:0]      rd_ptr_q;
	wire              full;
	wire              empty;
	wire              push;
	wire              pop;

	assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	assign empty     = (wr_ptr_q == rd_ptr_q);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign push      = in_valid & ~full;
	assign pop       = out_ready & ~empty;
	assign out_data  = mem[rd_ptr_q[AW-1:0]];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else if (flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
			rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
		end
	end
endmodule

// ****************************************
// Read registers and interrupt latch
// ****************************************
module scsirs_top
	import scsirs_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Host bus pins
	input  wire logic        chip_select_n,
	input  wire logic        host_read_strobe_n,
	input  wire logic        host_write_strobe_n,
	input  wire logic [2:0]  host_addr,
	output logic      [7:0]  host_data_out,
	output logic             host_data_oe,
	// DMA pins
	input  wire logic        dma_acknowledge_input_n,
	input  wire logic        end_of_process_input_n,
	output logic             dma_request_output,
	// Interrupt pin
	output logic             interrupt_request_output,
	output logic             interrupt_request_oe,
	// SCSI bus pins, active low
	input  wire logic [7:0]  scsi_data_n,
	input  wire logic        scsi_parity_n,
	input  wire logic        scsi_rst_n,
	input  wire logic        scsi_bsy_n,
	input  wire logic        scsi_req_n,
	input  wire logic        scsi_msg_n,
	input  wire logic        scsi_cd_n,
	input  wire logic        scsi_io_n,
	input  wire logic        scsi_sel_n,
	input  wire logic        scsi_atn_n,
	input  wire logic        scsi_ack_n,
	// Write-side register contents
	input  wire logic [7:0]  operating_mode,
	input  wire logic [7:0]  initiator_command,
	input  wire logic [7:0]  target_command,
	input  wire logic        last_byte_sent,
	input  wire logic        test_float_mode,
	// Sequencer handshakes
	input  wire scsirs_dir_e dma_dir,
	input  wire logic        send_byte_wanted,
	input  wire logic        selection_event,
	output logic             rx_ready,
	// Control back to the write side
	output logic             phase_compare_flag,
	output logic             transfer_inhibit,
	output logic             scsi_drivers_disable,
	output logic             clear_dma_mode,
	output logic             clear_icr_low
);
	localparam int NPIN = 26;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	wire [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1_q;
	logic [NPIN-1:0] pin_s2_q;
	logic [NPIN-1:0] pin_prev_q;

	assign pin_raw = {chip_select_n, host_read_strobe_n, host_write_strobe_n, host_addr,
		dma_acknowledge_input_n, end_of_process_input_n, scsi_rst_n, scsi_bsy_n, scsi_req_n,
		scsi_msg_n, scsi_cd_n, scsi_io_n, scsi_sel_n, scsi_atn_n, scsi_ack_n, scsi_parity_n,
		scsi_data_n};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_q   <= '1;
			pin_s2_q   <= '1;
			pin_prev_q <= '1;
		end else begin
			pin_s1_q   <= pin_raw;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// Active-high views of the synchronised pins
	wire       cs      = ~pin_s2_q[25];
	wire       rd      = ~pin_s2_q[24];
	wire       wr      = ~pin_s2_q[23];
	wire [2:0] addr    = pin_s2_q[22:20];
	wire       dma_acknowledge_input    = ~pin_s2_q[19];
	wire       eop     = ~pin_s2_q[18];
	wire       rst     = ~pin_s2_q[17];
	wire       bsy     = ~pin_s2_q[16];
	wire       req     = ~pin_s2_q[15];
	wire       msg     = ~pin_s2_q[14];
	wire       cd      = ~pin_s2_q[13];
	wire       io      = ~pin_s2_q[12];
	wire       sel     = ~pin_s2_q[11];
	wire       atn     = ~pin_s2_q[10];
	wire       ack     = ~pin_s2_q[9];
	wire       par     = ~pin_s2_q[8];
	wire [7:0] bus_dat = ~pin_s2_q[7:0];

	wire cs_prev   = ~pin_prev_q[25];
	wire rd_prev   = ~pin_prev_q[24];
	wire wr_prev   = ~pin_prev_q[23];
	wire dma_acknowledge_input_prev = ~pin_prev_q[19];
	wire rst_prev  = ~pin_prev_q[17];
	wire req_prev  = ~pin_prev_q[15];
	wire sel_prev  = ~pin_prev_q[11];
	wire ack_prev  = ~pin_prev_q[9];

	// ****************************************
	// Mode decode and host access strobes
	// ****************************************
	wire dma_mode   = operating_mode[`SCSIRS_MODE_DMA];
	wire mon_busy   = operating_mode[`SCSIRS_MODE_MONBSY];
	wire eodma_ie   = operating_mode[`SCSIRS_MODE_EODMA_IE];
	wire par_ie     = operating_mode[`SCSIRS_MODE_PAR_IE];
	wire par_en     = operating_mode[`SCSIRS_MODE_PAR_EN];
	wire target     = operating_mode[`SCSIRS_MODE_TARGET];
	wire send_dir   = (dma_dir == SCSIRS_DIR_SEND);

	wire cpu_rd      = cs & rd;
	wire cpu_rd_rise = cpu_rd & ~(cs_prev & rd_prev);
	wire dma_acknowledge_input_rd     = dma_acknowledge_input & rd;
	// Holding byte leaves the buffer at the end of the strobe so it stays put during the read
	wire dma_acknowledge_input_rd_end = ~dma_acknowledge_input_rd & (dma_acknowledge_input_prev & rd_prev);
	wire dma_acknowledge_input_wr     = dma_acknowledge_input & wr;
	wire dma_acknowledge_input_wr_rise = dma_acknowledge_input_wr & ~(dma_acknowledge_input_prev & wr_prev);
	wire clr_read    = cpu_rd_rise & (addr == `SCSIRS_LOC_CLEAR);         // RULE18
	wire pio_rd_data = cpu_rd_rise & (addr == `SCSIRS_LOC_DATA);

	// ****************************************
	// Phase compare
	// ****************************************
	assign phase_compare_flag = ({msg, cd, io} == target_command[2:0]);  // RULE10
	assign transfer_inhibit   = ~phase_compare_flag;                      // RULE10

	// ****************************************
	// Input holding buffer
	// ****************************************
	wire        cap_edge = target ? (ack & ~ack_prev) : (req & ~req_prev);
	wire        capture  = dma_mode & ~send_dir & phase_compare_flag & cap_edge; // RULE14
	wire        hold_valid;
	wire [7:0]  hold_data;
	wire        buf_in_ready;

	scsirs_fifo #(
		.WIDTH (`SCSIRS_FIFO_WIDTH),
		.DEPTH (`SCSIRS_FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.flush     (~dma_mode),                                           // RULE7
		.in_valid  (capture),
		.in_ready  (buf_in_ready),
		.in_data   (bus_dat),                                             // RULE14
		.out_valid (hold_valid),
		.out_ready (dma_acknowledge_input_rd_end & ~send_dir),
		.out_data  (hold_data)
	);

	// Sequencer must hold off the next byte while this is low, or the byte is lost
	assign rx_ready = buf_in_ready;

	// ****************************************
	// Parity check
	// ****************************************
	wire par_ok   = ^{bus_dat, par};
	wire sel_rise = sel & ~sel_prev & ~bsy;
	wire par_chk  = pio_rd_data | capture | sel_rise;                     // RULE17
	wire par_set  = par_en & par_chk & ~par_ok;                           // RULE8

	// ****************************************
	// End of transfer detection
	// ****************************************
	logic [3:0] eop_cnt_q;
	logic [3:0] eop_cnt_d;
	wire        eop_cond  = eop & dma_acknowledge_input & (rd | wr);
	wire        eop_valid = eop_cond && (eop_cnt_q == 4'(`SCSIRS_EOP_CYC - 1)); // RULE2

	assign eop_cnt_d = !eop_cond ? 4'h0 :
		(eop_cnt_q == 4'(`SCSIRS_EOP_CYC)) ? eop_cnt_q : eop_cnt_q + 4'h1;

	// ****************************************
	// Loss of busy
	// ****************************************
	logic [5:0] bsy_cnt_q;
	logic [5:0] bsy_cnt_d;
	// One event per loss of busy, so a clear read while busy stays low does not re-arm
	wire        bsy_lost = mon_busy & ~bsy &
		(bsy_cnt_q == 6'(`SCSIRS_SETTLE_CYC - 1));                        // RULE11

	assign bsy_cnt_d = (bsy | ~mon_busy) ? 6'h0 :
		(bsy_cnt_q == 6'(`SCSIRS_SETTLE_CYC)) ? bsy_cnt_q : bsy_cnt_q + 6'h1;

	// ****************************************
	// Status latches
	// ****************************************
	logic eodma_q;
	logic eodma_d;
	logic par_err_q;
	logic par_err_d;
	logic bsy_err_q;
	logic bsy_err_d;
	logic irq_q;
	logic irq_d;
	logic drq_send_q;
	logic drq_send_d;

	assign eodma_d   = dma_mode & (eop_valid | eodma_q);                  // RULE2 RULE3 RULE4
	assign par_err_d = par_set | (par_err_q & ~clr_read);                 // RULE8 RULE18
	assign bsy_err_d = bsy_lost | (bsy_err_q & ~clr_read);                // RULE11 RULE18

	wire irq_bus_reset = rst & ~rst_prev;                                 // RULE21
	wire irq_phase     = dma_mode & req & ~req_prev & ~phase_compare_flag;
	wire irq_eodma     = eodma_ie & dma_mode & eop_valid;
	wire irq_parity    = par_ie & par_set;
	wire irq_set       = irq_bus_reset | irq_phase | irq_eodma | irq_parity |
		bsy_lost | selection_event;                                       // RULE20
	assign irq_d       = irq_set | (irq_q & ~clr_read);                   // RULE18

	assign drq_send_d  = dma_mode & (send_byte_wanted | (drq_send_q & ~dma_acknowledge_input_wr_rise)); // RULE6 RULE7

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			eop_cnt_q  <= 4'h0;
			bsy_cnt_q  <= 6'h0;
			eodma_q    <= 1'b0;
			par_err_q  <= 1'b0;
			bsy_err_q  <= 1'b0;
			irq_q      <= 1'b0;
			drq_send_q <= 1'b0;
		end else begin
			eop_cnt_q  <= eop_cnt_d;
			bsy_cnt_q  <= bsy_cnt_d;
			eodma_q    <= eodma_d;
			par_err_q  <= par_err_d;
			bsy_err_q  <= bsy_err_d;
			irq_q      <= irq_d;
			drq_send_q <= drq_send_d;
		end
	end

	// ****************************************
	// Busy error consequences
	// ****************************************
	assign scsi_drivers_disable = bsy_err_q;                              // RULE12
	assign clear_dma_mode       = bsy_lost;                               // RULE4 RULE12
	assign clear_icr_low        = bsy_lost;                               // RULE12

	// ****************************************
	// Request and interrupt pins
	// ****************************************
	wire drq_recv = ~send_dir & hold_valid & ~dma_acknowledge_input_rd;
	assign dma_request_output = dma_mode & (send_dir ? drq_send_q : drq_recv); // RULE6 RULE7

	assign interrupt_request_output = irq_q;                              // RULE19
	assign interrupt_request_oe     = ~test_float_mode;                   // RULE19

	// ****************************************
	// Read data path
	// ****************************************
	wire [7:0] ctrl_view = {rst, bsy, req, msg, cd, io, sel, par};        // RULE1
	wire [7:0] stat_view = {eodma_q, dma_request_output, par_err_q, irq_q,
		phase_compare_flag, bsy_err_q, atn, ack};                         // RULE9 RULE13
	wire [7:0] tcr_view  = {last_byte_sent, 3'h0, target_command[3:0]};
	logic [7:0] loc_data;

	always_comb begin
		loc_data = 8'h00;
		unique case (addr)
			`SCSIRS_LOC_DATA:   loc_data = bus_dat;
			`SCSIRS_LOC_ICR:    loc_data = initiator_command;
			`SCSIRS_LOC_MODE:   loc_data = operating_mode;
			`SCSIRS_LOC_TCR:    loc_data = tcr_view;
			`SCSIRS_LOC_CTRL:   loc_data = ctrl_view;                      // RULE1
			`SCSIRS_LOC_STATUS: loc_data = stat_view;
			`SCSIRS_LOC_HOLD:   loc_data = hold_data;                      // RULE15
			`SCSIRS_LOC_CLEAR:  loc_data = 8'h00;
		endcase
	end

	// Host-side logic keeps acknowledge and chip select apart; acknowledge wins if not
	assign host_data_out = dma_acknowledge_input_rd ? hold_data : loc_data;                // RULE15 RULE16
	assign host_data_oe  = dma_acknowledge_input_rd | cpu_rd;
endmodule

`default_nettype wire

// ==== verif/scsi_read_status_and_interrupts_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Bench
// ****************************************
module scsi_read_status_and_interrupts_bench
	import scsirs_pkg::*;
;
	logic        sys_clk, arst_n, chip_select_n, host_read_strobe_n, host_write_strobe_n;
	logic [2:0]  host_addr;
	logic [7:0]  host_data_out, operating_mode, initiator_command, target_command, scsi_data_n;
	logic        host_data_oe, dma_acknowledge_input_n, end_of_process_input_n;
	logic        dma_request_output, interrupt_request_output, interrupt_request_oe;
	logic        scsi_parity_n, scsi_rst_n, scsi_bsy_n, scsi_req_n, scsi_msg_n, scsi_cd_n;
	logic        scsi_io_n, scsi_sel_n, scsi_atn_n, scsi_ack_n, last_byte_sent, test_float_mode;
	scsirs_dir_e dma_dir;
	logic        send_byte_wanted, selection_event, rx_ready, phase_compare_flag;
	logic        transfer_inhibit, scsi_drivers_disable, clear_dma_mode, clear_icr_low;
	int          fails = 0;
	int          checked = 0;

	scsirs_top dut (.*);
	scsirs_peer peer (.*);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Stands in for the write side, which obeys the clear pulse
	always @(posedge sys_clk) if (clear_dma_mode) operating_mode[1] <= 1'b0;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Chip select and acknowledge are never low together
	task automatic rd(input logic [2:0] a, input logic dma, input logic [7:0] exp);
		@(posedge sys_clk);
		#1 host_addr = a;
		chip_select_n = dma;
		dma_acknowledge_input_n = !dma;
		host_read_strobe_n = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 chk(host_data_out, exp);
		chip_select_n = 1'b1;
		dma_acknowledge_input_n = 1'b1;
		host_read_strobe_n = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	task automatic complete_run;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#50us;
		fails++;
		complete_run();
	end

	initial begin
		{chip_select_n, host_read_strobe_n, host_write_strobe_n} = '1;
		{dma_acknowledge_input_n, end_of_process_input_n} = '1;
		host_addr = 3'h0;
		{operating_mode, initiator_command, target_command} = {8'h80, 8'h5a, 8'h78};
		{last_byte_sent, test_float_mode, send_byte_wanted, selection_event} = 4'h8;
		dma_dir = SCSIRS_DIR_RECV;
		arst_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		rd(3'h5, 1'b0, 8'h08);
		rd(3'h0, 1'b0, 8'h00);
		rd(3'h1, 1'b0, 8'h5a);
		rd(3'h2, 1'b0, 8'h80);
		rd(3'h3, 1'b0, 8'h88);
		peer.ctl(9'h08a);
		rd(3'h4, 1'b0, 8'h44);
		rd(3'h5, 1'b0, 8'h02);
		peer.ctl(9'h100);
		repeat (4) @(posedge sys_clk);
		#1 peer.ctl(9'h000);
		rd(3'h5, 1'b0, 8'h18);
		rd(3'h4, 1'b0, 8'h00);
		chk({6'h0, interrupt_request_oe, interrupt_request_output}, 8'h03);
		test_float_mode = 1'b1;
		@(posedge sys_clk);
		#1 chk({7'h0, interrupt_request_oe}, 8'h00);
		test_float_mode = 1'b0;
		rd(3'h7, 1'b0, 8'h00);
		rd(3'h5, 1'b0, 8'h08);
		// Receive two bytes, the second with bad parity
		operating_mode = 8'h22;
		peer.send(8'ha5, 1'b0);
		peer.send(8'h3c, 1'b1);
		rd(3'h6, 1'b0, 8'ha5);
		chk({7'h0, dma_request_output}, 8'h01);
		rd(3'h6, 1'b1, 8'ha5);
		rd(3'h6, 1'b1, 8'h3c);
		rd(3'h5, 1'b0, 8'h28);
		rd(3'h7, 1'b0, 8'h00);
		// Eight good bytes fill the buffer
		repeat (8) peer.send(8'h11, 1'b0);
		chk({7'h0, rx_ready}, 8'h00);
		// Send request, then end of process on a write
		operating_mode = 8'h0a;
		dma_dir = SCSIRS_DIR_SEND;
		@(posedge sys_clk);
		#1 send_byte_wanted = 1'b1;
		@(posedge sys_clk);
		#1 send_byte_wanted = 1'b0;
		chk({7'h0, dma_request_output}, 8'h01);
		{dma_acknowledge_input_n, host_write_strobe_n, end_of_process_input_n} = '0;
		repeat (5) @(posedge sys_clk);
		#1 {dma_acknowledge_input_n, host_write_strobe_n, end_of_process_input_n} = '1;
		chk({7'h0, dma_request_output}, 8'h00);
		rd(3'h5, 1'b0, 8'h98);
		operating_mode = 8'h00;
		rd(3'h5, 1'b0, 8'h18);
		chk({7'h0, rx_ready}, 8'h01);
		rd(3'h7, 1'b0, 8'h00);
		@(posedge sys_clk);
		#1 selection_event = 1'b1;
		@(posedge sys_clk);
		#1 selection_event = 1'b0;
		rd(3'h5, 1'b0, 8'h18);
		rd(3'h7, 1'b0, 8'h00);
		// Loss of busy while monitored
		peer.ctl(9'h080);
		operating_mode = 8'h06;
		repeat (5) @(posedge sys_clk);
		#1 peer.ctl(9'h000);
		repeat (46) @(posedge sys_clk);
		#1 chk({6'h0, scsi_drivers_disable, operating_mode[1]}, 8'h02);
		rd(3'h5, 1'b0, 8'h1c);
		rd(3'h7, 1'b0, 8'h00);
		rd(3'h5, 1'b0, 8'h08);
		chk({7'h0, scsi_drivers_disable}, 8'h00);
		complete_run();
	end
endmodule

`default_nettype wire

// ==== verif/scsirs_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Port-level checks
// ****************************************
module scsirs_asserts (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic       chip_select_n,
	input wire logic       host_read_strobe_n,
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_data_out,
	input wire logic       host_data_oe,
	input wire logic       dma_request_output,
	input wire logic       interrupt_request_output,
	input wire logic       interrupt_request_oe,
	input wire logic       scsi_parity_n,
	input wire logic       scsi_rst_n,
	input wire logic       scsi_bsy_n,
	input wire logic       scsi_req_n,
	input wire logic       scsi_msg_n,
	input wire logic       scsi_cd_n,
	input wire logic       scsi_io_n,
	input wire logic       scsi_sel_n,
	input wire logic [7:0] operating_mode,
	input wire logic [7:0] target_command,
	input wire logic       test_float_mode,
	input wire logic       phase_compare_flag,
	input wire logic       transfer_inhibit,
	input wire logic       scsi_drivers_disable,
	input wire logic       clear_dma_mode,
	input wire logic       clear_icr_low
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Pins reach the logic through two sync flops, hence the depth of 2
	property p_ctl;
		host_data_oe && $past(host_addr, 2) == 3'h4 |-> host_data_out == ~$past({scsi_rst_n,
			scsi_bsy_n, scsi_req_n, scsi_msg_n, scsi_cd_n, scsi_io_n, scsi_sel_n, scsi_parity_n}, 2);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control view wrong");
	property p_phase;
		phase_compare_flag == (~$past({scsi_msg_n, scsi_cd_n, scsi_io_n}, 2) == target_command[2:0]);
	endproperty
	a_phase: assert property (p_phase) else $error("phase compare wrong");
	property p_inhibit; transfer_inhibit == !phase_compare_flag; endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit wrong");
	property p_settle; $rose(clear_dma_mode) |-> $past(scsi_bsy_n, 20) && operating_mode[2]; endproperty
	a_settle: assert property (p_settle) else $error("busy error too early");
	property p_pair; clear_dma_mode == clear_icr_low; endproperty
	a_pair: assert property (p_pair) else $error("clear pulses differ");
	property p_disable; $rose(clear_dma_mode) |=> scsi_drivers_disable; endproperty
	a_disable: assert property (p_disable) else $error("drivers not disabled");
	property p_drq_off; $fell(operating_mode[1]) |=> !dma_request_output; endproperty
	a_drq_off: assert property (p_drq_off) else $error("request kept");
	property p_oe; host_data_oe |-> !$past(host_read_strobe_n, 2); endproperty
	a_oe: assert property (p_oe) else $error("data driven without read");
	property p_clr;
		$fell(host_read_strobe_n) && !chip_select_n && host_addr == 3'h7
			|-> ##[2:4] !interrupt_request_output;
	endproperty
	a_clr: assert property (p_clr) else $error("latch not cleared");
	property p_float; test_float_mode |-> !interrupt_request_oe; endproperty
	a_float: assert property (p_float) else $error("irq driven in float");
	property p_rst_irq; $fell(scsi_rst_n) |-> ##[1:4] interrupt_request_output; endproperty
	a_rst_irq: assert property (p_rst_irq) else $error("no bus reset irq");

	c_busy: cover property ($rose(scsi_drivers_disable));
	c_irq: cover property ($rose(interrupt_request_output));
	c_drq: cover property ($fell(dma_request_output));
endmodule

bind scsirs_top scsirs_asserts u_asserts (.*);

`default_nettype wire

// ==== verif/scsirs_peer.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Far bus device, terminated lines idle high
// ****************************************
module scsirs_peer (
	input  wire logic      sys_clk,
	output var logic [7:0] scsi_data_n,
	output var logic       scsi_parity_n,
	output var logic       scsi_rst_n,
	output var logic       scsi_bsy_n,
	output var logic       scsi_req_n,
	output var logic       scsi_msg_n,
	output var logic       scsi_cd_n,
	output var logic       scsi_io_n,
	output var logic       scsi_sel_n,
	output var logic       scsi_atn_n,
	output var logic       scsi_ack_n
);
	initial begin
		scsi_data_n = '1;
		scsi_parity_n = 1'b1;
		{scsi_rst_n, scsi_bsy_n, scsi_req_n, scsi_msg_n, scsi_cd_n} = '1;
		{scsi_io_n, scsi_sel_n, scsi_atn_n, scsi_ack_n} = '1;
	end

	// Active high {rst,bsy,req,msg,cd,io,sel,atn,ack}
	task automatic ctl(input logic [8:0] v);
		{scsi_rst_n, scsi_bsy_n, scsi_req_n, scsi_msg_n, scsi_cd_n, scsi_io_n, scsi_sel_n,
			scsi_atn_n, scsi_ack_n} = ~v;
	endtask

	// Data settles before the strobe and holds past it, then the bus floats high
	task automatic send(input logic [7:0] b, input logic bad);
		@(posedge sys_clk);
		#1 scsi_data_n = ~b;
		scsi_parity_n = ~(~^b ^ bad);
		repeat (2) @(posedge sys_clk);
		#1 scsi_req_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 scsi_req_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 scsi_data_n = '1;
		scsi_parity_n = 1'b1;
	endtask
endmodule

`default_nettype wire
